// File: dv/srs_host.sv
// Host model shifting frames into the slave
`timescale 1ns/1ps
module srs_host (
	output logic sck,
	output logic chip_select_low,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_en
);
	logic [79:0] rx;
	initial {sck, chip_select_low, sdi} = 3'h2;
	// Clock stands low outside frames; sdi is spoiled after its hold time
	// So a slave that samples late takes the wrong bit
	task automatic xfer(input logic [79:0] tx, input int n);
		rx = '0;
		chip_select_low = 0;
		#240;
		for (int i = n - 1; i >= 0; i--) begin
			sdi = tx[i];
			#160 sck = 1;
			#80 sdi = ~sdi;
			#70 rx = {rx[78:0], sdo_en ? sdo : 1'bx};
			#10 sck = 0;
		end
		#200 chip_select_low = 1;
		#400;
	endtask
endmodule // srs_host

// File: dv/srs_slave_props.sv
// Checker for the serial slave
`timescale 1ns/1ps
module srs_slave_props
	import srs_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic chip_select_low,
	input wire logic rd_only,
	input wire logic sdo_en,
	input wire logic wr_stb,
	input wire logic [31:0] wr_data,
	input wire logic rd_stb,
	input wire logic [6:0] rd_addr,
	input wire logic [2:0] global_status_reg
);
	wire [2:0] gs = global_status_reg;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_one_op: assert property (!(wr_stb && rd_stb)) else $error("both");
	chk_wr_pulse: assert property (wr_stb |=> !wr_stb) else $error("wr");
	chk_rd_pulse: assert property (rd_stb |=> !rd_stb) else $error("rd");
	chk_sdo_off: assert property (chip_select_low [*8] |-> !sdo_en)
		else $error("sdo on");
	chk_sync_lag: assert property ($fell(chip_select_low) |=> !sdo_en [*2])
		else $error("no sync");
	chk_flag_keep: assert property (|($past(gs) & ~gs) |-> rd_stb
		&& rd_addr == GLOBAL_STATUS_REG_ADDR) else $error("clr");
	chk_ro_nowr: assert property (rd_only && $past(rd_only, 8) |-> !wr_stb)
		else $error("ro");
	chk_wr_hold: assert property (!wr_stb |-> $stable(wr_data))
		else $error("wd");
	cov_wr: cover property (wr_stb);
	cov_clr: cover property (rd_stb && rd_addr == GLOBAL_STATUS_REG_ADDR);
	cov_end: cover property ($fell(sdo_en));
endmodule // srs_slave_props
bind srs_slave srs_slave_props chk (.*);

// File: dv/test_srs_slave.sv
// Bench for the serial slave
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
bad_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module test_srs_slave;
	import srs_pkg::*;
	logic clock = 0, rst_n = 0, clk_en = 1, rd_only = 0, reset_event = 0;
	logic drv_err1_event = 0, drv_err2_event = 0, driver_disable_input = 0;
	logic [31:0] rd_data = '0;
	logic [15:0] ramp_state_motor_one = '0, ramp_state_motor_two = '0;
	wire sck, chip_select_low, sdi, sdo, sdo_en, wr_stb, rd_stb;
	wire driver_disable;
	wire [6:0] wr_addr, rd_addr;
	wire [31:0] wr_data;
	wire [2:0] global_status_reg;
	int bad_count = 0, cmp_count = 0, cyc = 0, wr_n = 0, rd_n = 0;
	srs_slave dut (.*);
	srs_host host (.*);
	always #20 clock = ~clock;
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task automatic final_report();
		$display("checks %0d bad %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clock) begin
		wr_n += wr_stb;
		rd_n += rd_stb;
		if (++cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic t_write();
		ramp_state_motor_one = 16'h0101;
		host.xfer(80'h8512345678, 40);
		tick(1);
		`CHK("addr", 7'h05, wr_addr)
		`CHK("data", 32'h12345678, wr_data)
		`CHK("stat", 8'h29, host.rx[39:32])
		`CHK("flag", 3'h1, global_status_reg)
		$display("write done");
	endtask
	task automatic t_read();
		rd_data = 32'h0000abcd;
		host.xfer(80'h01ffffffff, 40);
		tick(1);
		`CHK("echo", 32'h12345678, host.rx[31:0])
		`CHK("wr_n", 1, wr_n)
		`CHK("flag", 3'h0, global_status_reg)
		$display("read done");
	endtask
	task automatic t_chain();
		ramp_state_motor_one = '0;
		ramp_state_motor_two = 16'h0101;
		host.xfer({40'h80deadbeef, 40'h0200000000}, 80);
		tick(1);
		`CHK("reply", {8'h50, rd_data}, host.rx[79:40])
		`CHK("pass", 40'h80deadbeef, host.rx[39:0])
		`CHK("raddr", 7'h02, rd_addr)
		$display("chain done");
	endtask
	task automatic t_refuse();
		drv_err1_event = 1;
		driver_disable_input = 1;
		tick(1);
		drv_err1_event = 0;
		rd_only = 1;
		host.xfer(80'h86000000aa, 20);
		host.xfer(80'h86000000aa, 40);
		tick(1);
		rd_only = 0;
		host.xfer(80'h0000000000, 40);
		tick(1);
		`CHK("wr_n", 1, wr_n)
		`CHK("rd_n", 3, rd_n)
		`CHK("echo", 32'haa, host.rx[31:0])
		`CHK("flag", 3'h2, global_status_reg)
		`CHK("dis", 1'b1, driver_disable)
		$display("refuse done");
	endtask
	initial begin
		repeat (8) @(posedge clock);
		#2 rst_n = 1;
		`CHK("rst", 32'h0, wr_data)
		reset_event = 1;
		tick(1);
		reset_event = 0;
		tick(6);
		t_write();
		t_read();
		t_chain();
		t_refuse();
		final_report();
	end
endmodule // test_srs_slave

// File: include/srs_pkg.sv
// Package for the serial register access slave
package srs_pkg;
	localparam int FRAME_BITS = 40;
	localparam int DATA_BITS = 32;
	localparam int ADDR_BITS = 7;
	localparam logic [6:0] GLOBAL_STATUS_REG_ADDR = 7'h01;
	localparam int STAT_RESET_POS = 0;
	localparam int STAT_ERR1_POS = 1;
	localparam int STAT_ERR2_POS = 2;
	localparam int RAMP_VREACH_POS = 8;
	localparam int RAMP_STOPL_POS = 0;
	localparam logic [31:0] DATA_RESET = 32'h00000000;
	localparam int CLOCK_NS = 40;
	localparam int FILTER_NS = 20;
	localparam int FILTER_CYCLES = (FILTER_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam logic [1:0] FILT_MAX = 2'(FILTER_CYCLES);

	typedef struct packed {
		logic [1:0] sck_s;
		logic [1:0] cs_s;
		logic [1:0] sdi_s;
		logic [1:0] dis_s;
		logic sck_f;
		logic cs_f;
		logic sdi_f;
		logic dis_f;
		logic [1:0] sck_c;
		logic [1:0] cs_c;
		logic [1:0] sdi_c;
		logic [1:0] dis_c;
		logic [39:0] shreg;
		logic [5:0] bitcnt;
		logic sdo;
		logic sdo_en;
		logic prev_read;
		logic [6:0] prev_addr;
		logic [31:0] prev_wdata;
		logic wr_stb;
		logic [6:0] wr_addr;
		logic [31:0] wr_data;
		logic rd_stb;
		logic [6:0] rd_addr;
		logic [2:0] gflags;
		logic [7:0] status;
		logic drv_dis;
	} srs_state_t;
endpackage

// File: rtl/srs_slave.sv
// Serial register access slave with status byte and pipelined reads
// Notes on behaviour
// - Each frame is 40 bits: address byte then 32 data bits.
// - Bit 39 is direction: 1 write, 0 read.
// - After a read frame, next frame returns the addressed register data.
// - After a write frame, next frame echoes the written 32-bit data.
// - Read frames never store their dummy data.
// - Returned bits 39..32 always hold the status byte.
// - Status bits 0..2 copy reset and driver error flags.
// - Status bits 3,4 copy velocity reached from ramp bit 8.
// - Status bits 5,6 copy left stop from ramp bit 0; bit 7 zero.
// - Reset and driver error flags stay set until global status read.
// - Register data right aligned in the 32-bit field.
// - Input sampled on serial clock rise, output changed after fall.
// - Frames shift most significant bit first.
// - Extra clocks pass input to output delayed by 40 bits.
// - Select rising edge latches the last 40 bits as the command if at least 40 bits were clocked in.
// - Serial inputs and driver disable synchronised and glitch filtered.
// - Everything resets to zero except the select synchroniser and filter, which reset high.
// - Serial output driven only while select is low.
`timescale 1ns/1ps
module srs_slave
	import srs_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic sck,
	input wire logic chip_select_low,
	input wire logic sdi,
	input wire logic driver_disable_input,
	input wire logic [31:0] rd_data,
	input wire logic rd_only,
	input wire logic [15:0] ramp_state_motor_one,
	input wire logic [15:0] ramp_state_motor_two,
	input wire logic reset_event,
	input wire logic drv_err1_event,
	input wire logic drv_err2_event,
	output logic sdo,
	output logic sdo_en,
	output logic wr_stb,
	output logic [6:0] wr_addr,
	output logic [31:0] wr_data,
	output logic rd_stb,
	output logic [6:0] rd_addr,
	output logic [2:0] global_status_reg,
	output logic driver_disable
);
	srs_state_t r;
	srs_state_t next_r;

	// Glitch filter: output follows only after the level is stable
	function automatic logic [2:0] filt(input logic raw, input logic f,
		input logic [1:0] c);
		logic nf;
		logic [1:0] nc;
		nf = f;
		nc = 2'h0;
		if (raw != f) begin
			if (c >= FILT_MAX - 2'h1) begin
				nf = raw;
			end else begin
				nc = c + 2'h1;
			end
		end
		return {nf, nc};
	endfunction

	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic cs_fall;
	logic is_write;
	logic [6:0] fa;
	logic [31:0] fd;
	logic [31:0] ret;
	logic [7:0] stat;

	always_comb begin
		next_r = r;
		// Second flop only is read by the filters
		next_r.sck_s = {r.sck_s[0], sck};
		next_r.cs_s = {r.cs_s[0], chip_select_low};
		next_r.sdi_s = {r.sdi_s[0], sdi};
		next_r.dis_s = {r.dis_s[0], driver_disable_input};
		{next_r.sck_f, next_r.sck_c} = filt(r.sck_s[1], r.sck_f, r.sck_c);
		{next_r.cs_f, next_r.cs_c} = filt(r.cs_s[1], r.cs_f, r.cs_c);
		{next_r.sdi_f, next_r.sdi_c} = filt(r.sdi_s[1], r.sdi_f, r.sdi_c);
		{next_r.dis_f, next_r.dis_c} = filt(r.dis_s[1], r.dis_f, r.dis_c);
		next_r.drv_dis = r.dis_f;

		sck_rise = next_r.sck_f & ~r.sck_f;
		sck_fall = ~next_r.sck_f & r.sck_f;
		cs_rise = next_r.cs_f & ~r.cs_f;
		cs_fall = ~next_r.cs_f & r.cs_f;
		is_write = r.shreg[39];
		fa = r.shreg[38:32];
		fd = r.shreg[31:0];

		stat = 8'h00;
		stat[2:0] = r.gflags;
		stat[3] = ramp_state_motor_one[RAMP_VREACH_POS];
		stat[4] = ramp_state_motor_two[RAMP_VREACH_POS];
		stat[5] = ramp_state_motor_one[RAMP_STOPL_POS];
		stat[6] = ramp_state_motor_two[RAMP_STOPL_POS];
		next_r.status = stat;
		// Right aligned read data comes straight from the register file
		ret = r.prev_read ? rd_data : r.prev_wdata;

		next_r.wr_stb = 1'b0;
		next_r.rd_stb = 1'b0;

		if (cs_fall) begin
			// Load reply frame; MSB goes out first
			next_r.shreg = {r.status, ret};
			next_r.bitcnt = 6'h00;
			next_r.sdo = r.status[7];
			next_r.sdo_en = 1'b1;
		end else if (!r.cs_f) begin
			if (sck_rise) begin
				// Shift register doubles as the 40-bit daisy delay
				next_r.shreg = {r.shreg[38:0], r.sdi_f};
				if (r.bitcnt != 6'(FRAME_BITS)) begin
					next_r.bitcnt = r.bitcnt + 6'h01;
				end
			end
			if (sck_fall) begin
				next_r.sdo = r.shreg[39];
			end
		end

		if (cs_rise) begin
			next_r.sdo_en = 1'b0;
			next_r.sdo = 1'b0;
			if (r.bitcnt == 6'(FRAME_BITS)) begin
				next_r.prev_read = ~is_write;
				next_r.prev_addr = fa;
				next_r.prev_wdata = fd;
				if (is_write) begin
					// Read-only targets are reported by the register file
					if (!rd_only) begin
						next_r.wr_stb = 1'b1;
						next_r.wr_addr = fa;
						next_r.wr_data = fd;
					end
				end else begin
					next_r.rd_stb = 1'b1;
					next_r.rd_addr = fa;
					if (fa == GLOBAL_STATUS_REG_ADDR) begin
						next_r.gflags = 3'h0;
					end
				end
			end
		end
		// Set wins over clear
		next_r.gflags[STAT_RESET_POS] = next_r.gflags[STAT_RESET_POS]
			| reset_event;
		next_r.gflags[STAT_ERR1_POS] = next_r.gflags[STAT_ERR1_POS]
			| drv_err1_event;
		next_r.gflags[STAT_ERR2_POS] = next_r.gflags[STAT_ERR2_POS]
			| drv_err2_event;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			r <= '0;
			r.cs_s <= 2'h3;
			r.cs_f <= 1'b1;
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	assign sdo = r.sdo;
	assign sdo_en = r.sdo_en;
	assign wr_stb = r.wr_stb;
	assign wr_addr = r.wr_addr;
	assign wr_data = r.wr_data;
	assign rd_stb = r.rd_stb;
	assign rd_addr = r.rd_addr;
	assign global_status_reg = r.gflags;
	assign driver_disable = r.drv_dis;
endmodule // srs_slave
